// ==== bench/host_model.sv ====
// Host and radio side: slow clocks, flag reads, calibration replies.
// Assumes a 40 ns clk_i; slow clocks are sped up to 16 and 20 cycles.
`timescale 1ns/1ps
module host_model (
	// Clock and reset.
	input  logic clk_i,
	input  logic reset_i,
	// From the timer.
	input  logic irq_n_i,
	input  logic cal_req_i,
	// To the timer.
	output logic rc_o,
	output logic xt_o,
	output logic rd_o,
	output logic done_o
);
	logic [2:0] wait_q;
	// Free-running sources; their edges fall on system clock falling edges, away from the rising edges.
	initial begin
		{rc_o, xt_o} = 2'h0;
		fork
			forever #320 rc_o = ~rc_o;
			forever #400 xt_o = ~xt_o;
		join
	end
	// The host reads the flags on each interrupt; calibration takes five cycles.
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			{rd_o, done_o, wait_q} <= 5'h00;
		end else begin
			rd_o   <= !irq_n_i && !rd_o;
			wait_q <= cal_req_i ? wait_q + 3'h1 : 3'h0;
			done_o <= (wait_q == 3'h4);
		end
	end
endmodule // host_model

// ==== bench/tb_top.sv ====
// Bench for the wake-up timer: property writes, timed expiries, calibration.
// Assumes host_model drives the slow clocks, flag reads and cal replies.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
	logic        clk_i, reset_i, rc, xt, use_xtal_i, wr_i, rd, pup, sdx, cdone;
	logic        irq_n, flag, sleep, srx, stx, bat, cal, xst;
	logic [2:0]  wsel;
	logic [7:0]  wdat, cfg_o;
	logic [7:0]  tc [4] = '{8'h07, 8'h0B, 8'h03, 8'h23};
	logic [15:0] tm [4] = '{16'h0002, 16'h0001, 16'h0003, 16'h0100};
	logic [5:0]  te [4] = '{6'h20, 6'h01, 6'h21, 6'h00};
	int          tk [4] = '{16, 16, 20, 16};
	int          cyc, lastb, per, nbat, nrx, ntx, r0, t0, s, mismatches, num_checks;
	wake_timer dut (.clk_i(clk_i), .reset_i(reset_i), .rc_clk_i(rc), .xtal_clk_i(xt),
		.use_xtal_i(use_xtal_i), .wr_i(wr_i), .wr_sel_i(wsel), .wr_data_i(wdat),
		.flags_read_i(rd), .power_up_i(pup), .shutdown_exit_i(sdx), .preamble_i(1'b0),
		.packet_done_i(1'b0), .cal_done_i(cdone), .interrupt_out_n_o(irq_n),
		.timer_flag_o(flag), .sleep_o(sleep), .start_rx_o(srx), .start_tx_o(stx),
		.battery_check_o(bat), .cal_req_o(cal), .xtal_start_o(xst), .config_o(cfg_o));
	host_model host (.clk_i(clk_i), .reset_i(reset_i), .irq_n_i(irq_n), .cal_req_i(cal),
		.rc_o(rc), .xt_o(xt), .rd_o(rd), .done_o(cdone));
	// 25 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// Battery checks come once per expiry, so their spacing is the period.
	always @(posedge clk_i) begin
		cyc++;
		nrx += int'(srx === 1'b1);
		ntx += int'(stx === 1'b1);
		if (bat === 1'b1) begin
			per = cyc - lastb;
			lastb = cyc;
			nbat++;
		end
	end
	////////////////////////////////////////
	task automatic wr(input logic [2:0] sel, input logic [7:0] d);
		@(posedge clk_i);
		{wr_i, wsel, wdat} <= {1'b1, sel, d};
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	// Waits for n more expiries; a stall ends the run.
	task automatic wait_bat(input int n);
		s = nbat + n;
		for (int k = 0; k < 10000 && nbat < s; k++) @(negedge clk_i);
		if (nbat < s) begin
			`CHK(nbat, s)
			end_of_test();
		end
	endtask
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Main sequence.
	initial begin
		{reset_i, use_xtal_i, wr_i, pup, sdx, wsel, wdat} = 16'h8000;
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		`CHK({irq_n, cfg_o}, 9'h100)
		wr(3'h5, 8'h01);
		for (int i = 0; i < 4; i++) begin
			wr(3'h1, tm[i][15:8]);
			wr(3'h2, tm[i][7:0]);
			wr(3'h3, {2'h0, te[i]});
			wr(3'h0, tc[i]);
			use_xtal_i <= (tk[i] == 20);
			wait_bat(2);
			{r0, t0} = {nrx, ntx};
			wait_bat(1);
			`CHK(per, tm[i] * (4 ** te[i][4:0]) * tk[i])
			// A duty window lasts one slow tick, so let it close before the state check.
			repeat (tk[i] + 4) @(negedge clk_i);
			`CHK({cfg_o, sleep, cal}, {tc[i], te[i][5], 1'b0})
			`CHK(nrx > r0, tc[i][3:2] == 2'h1)
			`CHK(ntx > t0, tc[i][3:2] == 2'h2)
			$display("Test %0d done", i);
		end
		wr(3'h5, 8'h00);
		wait_bat(2);
		`CHK({irq_n, flag}, 2'h3)
		wr(3'h5, 8'h01);
		repeat (8) @(negedge clk_i);
		`CHK({irq_n, flag}, 2'h2)
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_i);
			{pup, sdx} <= i ? 2'h1 : 2'h2;
			@(posedge clk_i);
			{pup, sdx} <= 2'h0;
			s = 0;
			repeat (12) @(negedge clk_i) s += int'(xst === 1'b1);
			`CHK({s > 0, cal}, 2'h2)
		end
		wr(3'h0, 8'h13);
		for (s = 0; s < 20000 && cal !== 1'b1; s++) @(negedge clk_i);
		`CHK(cal, 1'b1)
		repeat (12) @(negedge clk_i);
		wr(3'h0, 8'h02);
		s = nbat;
		repeat (5000) @(negedge clk_i);
		`CHK(nbat, s)
		$display("Test 9 done");
		end_of_test();
	end
endmodule // tb_top

// ==== bench/wake_timer_checker.sv ====
// Port checker for the wake-up timer.
// Assumes clk_i is the only clock and reset_i is asynchronous.
`timescale 1ns/1ps
module wake_timer_checker (
	// Clock, reset and host pulses.
	input logic       clk_i,
	input logic       reset_i,
	input logic       power_up_i,
	input logic       flags_read_i,
	// Watched outputs.
	input logic       interrupt_out_n_o,
	input logic       timer_flag_o,
	input logic       start_rx_o,
	input logic       start_tx_o,
	input logic       battery_check_o,
	input logic       cal_req_o,
	input logic       xtal_start_o,
	input logic [7:0] config_o
);
	// One domain, so one clocking and one reset for all checks.
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_irq_has_flag: assert property (!interrupt_out_n_o |-> timer_flag_o)
		else $error("irq without flag");
	a_rx_at_wake: assert property (start_rx_o |-> timer_flag_o && config_o[3:2] == 2'h1)
		else $error("bad rx start");
	a_tx_at_wake: assert property (start_tx_o |-> timer_flag_o && config_o[3:2] == 2'h2)
		else $error("bad tx start");
	a_bat_enabled: assert property (battery_check_o |-> config_o[1:0] == 2'h3)
		else $error("bad battery check");
	a_flag_cleared: assert property ($fell(timer_flag_o) |-> $past(flags_read_i))
		else $error("flag fell unread");
	a_wake_enabled: assert property ($rose(timer_flag_o) |-> config_o[0])
		else $error("expiry while off");
	a_cal_xtal_on: assert property (cal_req_o |-> xtal_start_o)
		else $error("cal without crystal");
	a_powerup_cal: assert property (power_up_i |-> ##[1:3] cal_req_o)
		else $error("no power-up cal");
endmodule // wake_timer_checker
////////////////////////////////////////
// Every timer instance gets a checker.
bind wake_timer wake_timer_checker chk (.clk_i(clk_i), .reset_i(reset_i),
	.power_up_i(power_up_i), .flags_read_i(flags_read_i),
	.interrupt_out_n_o(interrupt_out_n_o), .timer_flag_o(timer_flag_o),
	.start_rx_o(start_rx_o), .start_tx_o(start_tx_o), .battery_check_o(battery_check_o),
	.cal_req_o(cal_req_o), .xtal_start_o(xtal_start_o), .config_o(config_o));

// ==== hw/wake_period_counter.v ====
// Period counter of the wake-up timer: counts 32 kHz ticks and flags expiry.
// Assumes the tick input is already synchronised to clk_i and one cycle wide.
`timescale 1ns/1ps
module wake_period_counter #(
	parameter MW = 16,
	parameter EW = 5
) (
	// Clock and reset.
	input  wire          clk_i,
	input  wire          reset_i,
	// Control.
	input  wire          run_i,
	input  wire          tick_i,
	input  wire [MW-1:0] mant_i,
	input  wire [EW-1:0] exp_i,
	// Expiry.
	output reg           expire_o
);
	// Period in ticks is mantissa times four to the power of the exponent.
	localparam CW = MW + 2 * 31;
	reg [CW-1:0] count_q;
	reg [CW-1:0] period_q;
	wire [CW-1:0] new_period = {{(CW-MW){1'b0}}, mant_i} << {exp_i, 1'b0};

	// Period is latched only at a period start so an edit never cuts one short.
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			count_q  <= {CW{1'b0}};
			period_q <= {CW{1'b0}};
			expire_o <= 1'b0;
		end else begin
			expire_o <= 1'b0;
			if (!run_i) begin
				count_q  <= {CW{1'b0}};
				period_q <= new_period;
			end else if (tick_i) begin
				if (count_q + 1'b1 >= period_q) begin
					count_q  <= {CW{1'b0}};
					period_q <= new_period;
					expire_o <= 1'b1;
				end else begin
					count_q <= count_q + 1'b1;
				end
			end
		end
	end
endmodule // wake_period_counter

// ==== hw/wake_timer.v ====
// Wake-up timer with duty cycling, battery checks and RC calibration requests.
// Assumes clk_i is the fast system clock and the 32 kHz sources arrive as pins.
//
// How it works
// - Tick source picks RC or crystal 32 kHz.
// - Enabled timer counts the programmed period repeatedly.
// - Expiry drives interrupt low when mask allows.
// - Period equals mantissa times four-power exponent.
// - Calibrate RC at power-up and shutdown exit.
// - Periodic calibration gated by enable, interval field.
// - Calibration compares RC against main crystal.
// - Each calibration starts the main crystal.
// - Battery check on every expiry when enabled.
// - Select: off, receive wake, transmit wake.
// - Exponent shares register with state select.
// - State select picks ready or sleep afterward.
// - Duration register sets active window length.
// - Transmit done returns at once to state.
// - Preamble extends receive window, two durations max.
`timescale 1ns/1ps
`include "wake_timer_defs.vh"
module wake_timer #(
	parameter MW = 16,
	parameter EW = 5
) (
	// Clock and reset.
	input  wire       clk_i,
	input  wire       reset_i,
	// 32 kHz sources and source select.
	input  wire       rc_clk_i,
	input  wire       xtal_clk_i,
	input  wire       use_xtal_i,
	// Property write port.
	input  wire       wr_i,
	input  wire [2:0] wr_sel_i,
	input  wire [7:0] wr_data_i,
	// Host side.
	input  wire       flags_read_i,
	input  wire       power_up_i,
	input  wire       shutdown_exit_i,
	// Radio feedback.
	input  wire       preamble_i,
	input  wire       packet_done_i,
	input  wire       cal_done_i,
	// Status and outputs.
	output reg        interrupt_out_n_o,
	output reg        timer_flag_o,
	output reg        sleep_o,
	output reg        start_rx_o,
	output reg        start_tx_o,
	output reg        battery_check_o,
	output reg        cal_req_o,
	output reg        xtal_start_o,
	output reg  [7:0] config_o
);
	////////////////////////////////////////////////////////////////////////
	// Property registers.
	reg [7:0] config_q;
	reg [7:0] mant_high_q;
	reg [7:0] mant_low_q;
	reg [7:0] exp_state_q;
	reg [7:0] duration_q;
	reg       int_mask_q;

	// Decoding used more than once: is this write aimed at a selector.
	function hit;
		input       w;
		input [2:0] s;
		input [2:0] target;
		begin
			hit = w && (s == target);
		end
	endfunction

	// Plain property writes: byte-wide, except the one-bit interrupt mask.
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			config_q    <= `CFG_RESET;
			mant_high_q <= `MANT_HIGH_RESET;
			mant_low_q  <= `MANT_LOW_RESET;
			exp_state_q <= `EXP_RESET;
			duration_q  <= `DUR_RESET;
			int_mask_q  <= 1'b0;
		end else begin
			if (hit(wr_i, wr_sel_i, `SEL_CONFIG))
				config_q <= wr_data_i;
			if (hit(wr_i, wr_sel_i, `SEL_MANT_HIGH))
				mant_high_q <= wr_data_i;
			if (hit(wr_i, wr_sel_i, `SEL_MANT_LOW))
				mant_low_q <= wr_data_i;
			if (hit(wr_i, wr_sel_i, `SEL_EXP_STATE))
				exp_state_q <= wr_data_i;
			if (hit(wr_i, wr_sel_i, `SEL_DURATION))
				duration_q <= wr_data_i;
			if (hit(wr_i, wr_sel_i, `SEL_INT_MASK))
				int_mask_q <= wr_data_i[0];
		end
	end

	wire       enable    = config_q[`CFG_ENABLE_BIT];
	wire       batt_en   = config_q[`CFG_BATTERY_BIT];
	wire [1:0] duty_sel  = config_q[`CFG_DUTY_MSB:`CFG_DUTY_LSB];
	wire       cal_en    = config_q[`CFG_CAL_EN_BIT];
	wire [2:0] cal_int   = config_q[`CFG_CAL_INT_MSB:`CFG_CAL_INT_LSB];
	wire       state_sel = exp_state_q[`EXP_STATE_BIT];

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers on both slow clocks, then an edge detect.
	reg [1:0] rc_sync_q;
	reg [1:0] xt_sync_q;
	reg       sel_sync1_q;
	reg       sel_sync2_q;
	reg       src_last_q;
	reg       tick_q;
	wire      src_now = sel_sync2_q ? xt_sync_q[1] : rc_sync_q[1];

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rc_sync_q   <= 2'h0;
			xt_sync_q   <= 2'h0;
			sel_sync1_q <= 1'b0;
			sel_sync2_q <= 1'b0;
			src_last_q  <= 1'b0;
			tick_q      <= 1'b0;
		end else begin
			rc_sync_q   <= {rc_sync_q[0], rc_clk_i};
			xt_sync_q   <= {xt_sync_q[0], xtal_clk_i};
			sel_sync1_q <= use_xtal_i;
			sel_sync2_q <= sel_sync1_q;
			src_last_q  <= src_now;
			tick_q      <= src_now & ~src_last_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Period counter.
	wire expire;

	wake_period_counter #(
		.MW (MW),
		.EW (EW)
	) u_counter (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.run_i    (enable),
		.tick_i   (tick_q),
		.mant_i   ({mant_high_q, mant_low_q}),
		.exp_i    (exp_state_q[`EXP_MSB:`EXP_LSB]),
		.expire_o (expire)
	);

	////////////////////////////////////////////////////////////////////////
	// Interrupt flag: an expiry in the read cycle wins over the clear.
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			timer_flag_o      <= 1'b0;
			interrupt_out_n_o <= 1'b1;
		end else begin
			if (expire)
				timer_flag_o <= 1'b1;
			else if (flags_read_i)
				timer_flag_o <= 1'b0;
			interrupt_out_n_o <= ~((timer_flag_o | expire) & int_mask_q
				& ~(flags_read_i & ~expire));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wake sequencer, one-hot.
	localparam ST_IDLE   = 3'b001;
	localparam ST_ACTIVE = 3'b010;
	localparam ST_EXTEND = 3'b100;
	reg [2:0] state_q;
	reg [7:0] dur_cnt_q;
	reg [1:0] dur_used_q;
	wire      dur_end = tick_q && (dur_cnt_q + 8'h01 >= duration_q);

	// The window is counted in slow ticks so it tracks the selected 32 kHz source.
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q         <= ST_IDLE;
			dur_cnt_q       <= 8'h00;
			dur_used_q      <= 2'h0;
			sleep_o         <= 1'b0;
			start_rx_o      <= 1'b0;
			start_tx_o      <= 1'b0;
			battery_check_o <= 1'b0;
		end else begin
			start_rx_o      <= 1'b0;
			start_tx_o      <= 1'b0;
			battery_check_o <= expire & batt_en;
			case (state_q)
			ST_IDLE: begin
				if (expire) begin
					dur_cnt_q  <= 8'h00;
					dur_used_q <= 2'h1;
					if (duty_sel == `DUTY_RX) begin
						start_rx_o <= 1'b1;
						sleep_o    <= 1'b0;
						state_q    <= ST_ACTIVE;
					end else if (duty_sel == `DUTY_TX) begin
						start_tx_o <= 1'b1;
						sleep_o    <= 1'b0;
						state_q    <= ST_ACTIVE;
					end else begin
						sleep_o <= state_sel;
					end
				end
			end
			ST_ACTIVE: begin
				if (duty_sel == `DUTY_TX && packet_done_i) begin
					sleep_o <= state_sel;
					state_q <= ST_IDLE;
				end else if (duty_sel == `DUTY_RX && preamble_i) begin
					state_q <= ST_EXTEND;
				end else if (dur_end) begin
					sleep_o <= state_sel;
					state_q <= ST_IDLE;
				end else if (tick_q) begin
					dur_cnt_q <= dur_cnt_q + 8'h01;
				end
			end
			ST_EXTEND: begin
				if (packet_done_i) begin
					sleep_o <= state_sel;
					state_q <= ST_IDLE;
				end else if (dur_end) begin
					dur_cnt_q <= 8'h00;
					if (dur_used_q >= `MAX_DURATIONS) begin
						sleep_o <= state_sel;
						state_q <= ST_IDLE;
					end else begin
						dur_used_q <= dur_used_q + 2'h1;
					end
				end else if (tick_q) begin
					dur_cnt_q <= dur_cnt_q + 8'h01;
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// RC calibration requests; the measurement itself is done by the
	// analog trim engine, which signals cal_done_i when matched to the crystal.
	reg [22:0] cal_cnt_q;
	wire [22:0] cal_limit = {7'h00, `CAL_BASE_TICKS} << cal_int;

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cal_cnt_q    <= 23'h000000;
			cal_req_o    <= 1'b0;
			xtal_start_o <= 1'b0;
		end else begin
			if (power_up_i || shutdown_exit_i) begin
				cal_req_o    <= 1'b1;
				xtal_start_o <= 1'b1;
			end else if (cal_en && tick_q && cal_cnt_q + 23'h000001 >= cal_limit) begin
				cal_req_o    <= 1'b1;
				xtal_start_o <= 1'b1;
			end else if (cal_done_i) begin
				cal_req_o    <= 1'b0;
				xtal_start_o <= 1'b0;
			end
			if (!cal_en || (tick_q && cal_cnt_q + 23'h000001 >= cal_limit))
				cal_cnt_q <= 23'h000000;
			else if (tick_q)
				cal_cnt_q <= cal_cnt_q + 23'h000001;
		end
	end

	// Configuration readback.
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			config_o <= `CFG_RESET;
		else
			config_o <= config_q;
	end
endmodule // wake_timer

// ==== hw/wake_timer_defs.vh ====
// Shared constants for the wake-up timer block.
// Assumes inclusion by bare name from the design files.
`ifndef WAKE_TIMER_DEFS_VH
`define WAKE_TIMER_DEFS_VH
// Configuration register field positions.
`define CFG_ENABLE_BIT      0
`define CFG_BATTERY_BIT     1
`define CFG_DUTY_LSB        2
`define CFG_DUTY_MSB        3
`define CFG_CAL_EN_BIT      4
`define CFG_CAL_INT_LSB     5
`define CFG_CAL_INT_MSB     7
// Exponent and state register field positions.
`define EXP_LSB             0
`define EXP_MSB             4
`define EXP_STATE_BIT       5
// Reset values.
`define CFG_RESET           8'h00
`define MANT_HIGH_RESET     8'h00
`define MANT_LOW_RESET      8'h01
`define EXP_RESET           8'h00
`define DUR_RESET           8'h01
// Duty-cycle select codes.
`define DUTY_OFF            2'h0
`define DUTY_RX             2'h1
`define DUTY_TX             2'h2
// Register selectors on the write port.
`define SEL_CONFIG          3'h0
`define SEL_MANT_HIGH       3'h1
`define SEL_MANT_LOW        3'h2
`define SEL_EXP_STATE       3'h3
`define SEL_DURATION        3'h4
`define SEL_INT_MASK        3'h5
// Longest active window including its extension, in durations.
`define MAX_DURATIONS       2'h2
// Base calibration interval in ticks, doubled per step of the interval field.
`define CAL_BASE_TICKS      16'h0400
`endif
